// ===== hdl/fpc_pkg.sv
// Constants and types for the flash protection and command parameter block
package fpc_pkg;
    // Register bus geometry
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;

    // Register offsets (one register per address)
    localparam logic [ADDR_W-1:0] OFS_PARAM_INDEX = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_FLASH_STATUS = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_PFLASH_PROT = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_DFLASH_PROT = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_PARAM_DATA = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_RSV_ZERO = 3'h5;
    localparam logic [ADDR_W-1:0] OFS_RSV_ONE = 3'h6;

    // Status register fields
    localparam int STAT_COMMAND_COMPLETE_FLAG_BIT = 7;
    localparam int STAT_VIOL_BIT = 5;

    // Program-flash protection fields
    localparam int PF_OPEN_BIT = 7;
    localparam int PF_HDIS_BIT = 5;
    localparam int PF_HS_LSB = 3;
    localparam int PF_LDIS_BIT = 2;
    localparam int PF_LS_LSB = 0;
    localparam logic [BYTE_W-1:0] PF_USED_MASK = 8'hBF;
    localparam logic [BYTE_W-1:0] PF_FAULT_VALUE = 8'h7F;

    // Data-flash protection fields
    localparam int DF_OFF_BIT = 7;
    localparam int DF_SIZE_W = 5;
    localparam logic [BYTE_W-1:0] DF_USED_MASK = 8'h9F;
    localparam logic [BYTE_W-1:0] DF_FAULT_VALUE = 8'h1F;

    // Data-flash protected window
    localparam logic [22:0] DF_BASE_ADDR = 23'h10_0000;
    localparam int DF_SECTOR_BYTES = 256;
    localparam int DF_MAX_BYTES = 4096;

    // Parameter array
    localparam int PARAM_WORDS = 6;
    localparam int INDEX_W = 3;
    localparam logic [DATA_W-1:0] UNUSED_WORD = 16'h0000;

    // Allowed scenario moves: row = from, bit = to
    localparam logic [7:0] SCEN_ALLOWED [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};

    // Default mapping {open,hdis,ldis} -> scenario, three bits per entry
    localparam logic [23:0] SCEN_MAP_DEFAULT = 24'hFAC_688;

    typedef enum logic {CMD_IDLE, CMD_BUSY} fpc_cmd_state_type;
endpackage

// ===== hdl/fpc_protect_cmd.sv
// Flash protection registers, status flags and indexed command parameter array
//
// Behaviour
// - Disallowed program-flash scenario writes are discarded
// - Program-flash register equals enforced scenario
// - Scenario moves follow fixed allowed table
// - Data-flash size accepted only when larger
// - Data-flash off bit only goes 1 to 0
// - Off bit set means nothing protected
// - Reset sequence loads data-flash protection byte
// - Double fault at load gives maximum protection
// - Protected program/erase refused, violation flag set
// - Block erase refused while data-flash protection on
// - Window at base, (size+1)*256 bytes, max 4096
// - Six 16-bit words, 3-bit index, byte access
// - Writing 1 to complete flag launches command
// - Parameter array locked while command runs
// - Results readable after complete flag returns
// - Index 6 and 7 store nothing, read zero
// - Factory reserved registers read zero, ignore writes
// - Range sizes writable only while range off
// - Parameter writes ignored while flag is 0
`timescale 1ns/10ps
module fpc_protect_cmd #(
    parameter logic [23:0] SCEN_MAP = fpc_pkg::SCEN_MAP_DEFAULT
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Register bus
    input wire logic [fpc_pkg::ADDR_W-1:0] regAddr,
    input wire logic [fpc_pkg::DATA_W-1:0] regWrData,
    input wire logic [1:0] regByteEn,
    input wire logic regWrStrobe,
    input wire logic regRdStrobe,
    output logic [fpc_pkg::DATA_W-1:0] regRdData,
    // Configuration load from the reset sequence
    input wire logic cfgValid,
    input wire logic [fpc_pkg::BYTE_W-1:0] cfgPflashByte,
    input wire logic [fpc_pkg::BYTE_W-1:0] cfgDflashByte,
    input wire logic cfgDoubleFault,
    // Command engine
    output logic cmdLaunch,
    input wire logic cmdDone,
    input wire logic resWrEn,
    input wire logic [fpc_pkg::INDEX_W-1:0] resIndex,
    input wire logic [fpc_pkg::DATA_W-1:0] resData,
    output logic [fpc_pkg::PARAM_WORDS*fpc_pkg::DATA_W-1:0] paramFlat,
    output logic commandComplete,
    // Protection check for program and erase
    input wire logic chkReq,
    input wire logic [22:0] chkAddr,
    input wire logic chkBlockErase,
    output logic chkDenied,
    output logic protectionViolation,
    output logic [fpc_pkg::BYTE_W-1:0] pflashProtection,
    output logic [fpc_pkg::BYTE_W-1:0] dflashProtection
);
    import fpc_pkg::*;

    fpc_cmd_state_type cmdState_ff, nxt_cmdState;
    logic violation_ff, nxt_violation;
    logic [BYTE_W-1:0] pflashProt_ff, nxt_pflashProt;
    logic [BYTE_W-1:0] dflashProt_ff, nxt_dflashProt;
    logic [INDEX_W-1:0] paramIndex_ff, nxt_paramIndex;
    logic [DATA_W-1:0] params_ff [PARAM_WORDS];
    logic [DATA_W-1:0] nxt_params [PARAM_WORDS];
    logic [DATA_W-1:0] rdData_ff, nxt_rdData;

    logic wrIndex, wrStatus, wrPflash, wrDflash, wrParam;
    logic [BYTE_W-1:0] pfCandidate;
    logic pfAllowed;
    logic dfEnabled;
    logic [DF_SIZE_W-1:0] dfSizeCur, dfSizeWr;

    // Scenario number of a program-flash protection value
    function automatic logic [2:0] scenarioOf(input logic [BYTE_W-1:0] v);
        logic [2:0] key;
        key = {v[PF_OPEN_BIT], v[PF_HDIS_BIT], v[PF_LDIS_BIT]};
        return SCEN_MAP[3*key +: 3];
    endfunction

    // True when an address lies in the protected data-flash window
    function automatic logic inDflashWindow(input logic [22:0] a, input logic [DF_SIZE_W-1:0] sz);
        logic [22:0] span;
        logic [22:0] limit;
        span = 23'((32'(sz) + 32'd1) * DF_SECTOR_BYTES);
        limit = (span > 23'(DF_MAX_BYTES)) ? 23'(DF_MAX_BYTES) : span;
        return (a >= DF_BASE_ADDR) && (a < DF_BASE_ADDR + limit);
    endfunction

    // Write decode
    // Byte registers sit in lane 0, so a write without that lane is dropped
    always_comb begin
        wrIndex = regWrStrobe && regByteEn[0] && (regAddr == OFS_PARAM_INDEX);
        wrStatus = regWrStrobe && regByteEn[0] && (regAddr == OFS_FLASH_STATUS);
        wrPflash = regWrStrobe && regByteEn[0] && (regAddr == OFS_PFLASH_PROT);
        wrDflash = regWrStrobe && regByteEn[0] && (regAddr == OFS_DFLASH_PROT);
        wrParam = regWrStrobe && (regAddr == OFS_PARAM_DATA);
    end

    // Program-flash candidate: size fields only move while their range is off
    always_comb begin
        pfCandidate = regWrData[BYTE_W-1:0] & PF_USED_MASK;
        if (!pflashProt_ff[PF_HDIS_BIT]) begin
            pfCandidate[PF_HS_LSB +: 2] = pflashProt_ff[PF_HS_LSB +: 2];
        end
        if (!pflashProt_ff[PF_LDIS_BIT]) begin
            pfCandidate[PF_LS_LSB +: 2] = pflashProt_ff[PF_LS_LSB +: 2];
        end
        pfAllowed = SCEN_ALLOWED[scenarioOf(pflashProt_ff)][scenarioOf(pfCandidate)];
    end

    // Protection registers
    always_comb begin
        dfSizeCur = dflashProt_ff[DF_SIZE_W-1:0];
        dfSizeWr = regWrData[DF_SIZE_W-1:0];
        nxt_pflashProt = pflashProt_ff;
        nxt_dflashProt = dflashProt_ff;
        if (cfgValid) begin
            // Load from the configuration field during the reset sequence
            nxt_pflashProt = cfgDoubleFault ? PF_FAULT_VALUE : (cfgPflashByte & PF_USED_MASK);
            nxt_dflashProt = cfgDoubleFault ? DF_FAULT_VALUE : (cfgDflashByte & DF_USED_MASK);
        end else begin
            if (wrPflash && pfAllowed) begin
                nxt_pflashProt = pfCandidate;
            end
            if (wrDflash) begin
                nxt_dflashProt[DF_OFF_BIT] = dflashProt_ff[DF_OFF_BIT] & regWrData[DF_OFF_BIT];
                if (dfSizeWr > dfSizeCur) begin
                    nxt_dflashProt[DF_SIZE_W-1:0] = dfSizeWr;
                end
            end
        end
    end

    // Protection check; off bit masks the size field entirely
    always_comb begin
        dfEnabled = !dflashProt_ff[DF_OFF_BIT];
        chkDenied = chkReq && dfEnabled
            && (chkBlockErase || inDflashWindow(chkAddr, dfSizeCur));
    end

    // Command state, launch and violation flag
    always_comb begin
        nxt_cmdState = cmdState_ff;
        nxt_violation = violation_ff;
        cmdLaunch = 1'b0;
        if (cmdState_ff == CMD_IDLE) begin
            if (wrStatus && regWrData[STAT_COMMAND_COMPLETE_FLAG_BIT]) begin
                cmdLaunch = 1'b1;
                nxt_cmdState = CMD_BUSY;
            end
        end else begin
            if (cmdDone) begin
                nxt_cmdState = CMD_IDLE;
            end
        end
        if (wrStatus && regWrData[STAT_VIOL_BIT]) begin
            nxt_violation = 1'b0;
        end
        // A refusal in the clearing cycle still leaves the flag set
        if (chkDenied) begin
            nxt_violation = 1'b1;
        end
    end

    // Index register and parameter array
    always_comb begin
        nxt_paramIndex = paramIndex_ff;
        nxt_params = params_ff;
        if (wrIndex) begin
            nxt_paramIndex = regWrData[INDEX_W-1:0];
        end
        // Indices past the array fall through with no storage
        if (wrParam && (cmdState_ff == CMD_IDLE) && (32'(paramIndex_ff) < PARAM_WORDS)) begin
            if (regByteEn[0]) begin
                nxt_params[paramIndex_ff][BYTE_W-1:0] = regWrData[BYTE_W-1:0];
            end
            if (regByteEn[1]) begin
                nxt_params[paramIndex_ff][DATA_W-1:BYTE_W] = regWrData[DATA_W-1:BYTE_W];
            end
        end
        // Only the engine writes the array while busy, to return results
        if (resWrEn && (cmdState_ff == CMD_BUSY) && (32'(resIndex) < PARAM_WORDS)) begin
            nxt_params[resIndex] = resData;
        end
    end

    // Read mux, answered in the following cycle
    always_comb begin
        nxt_rdData = rdData_ff;
        if (regRdStrobe) begin
            nxt_rdData = UNUSED_WORD;
            case (regAddr)
                OFS_PARAM_INDEX: nxt_rdData[INDEX_W-1:0] = paramIndex_ff;
                OFS_FLASH_STATUS: begin
                    nxt_rdData[STAT_COMMAND_COMPLETE_FLAG_BIT] = (cmdState_ff == CMD_IDLE);
                    nxt_rdData[STAT_VIOL_BIT] = violation_ff;
                end
                OFS_PFLASH_PROT: nxt_rdData[BYTE_W-1:0] = pflashProt_ff;
                OFS_DFLASH_PROT: nxt_rdData[BYTE_W-1:0] = dflashProt_ff;
                OFS_PARAM_DATA: begin
                    if (32'(paramIndex_ff) < PARAM_WORDS) begin
                        nxt_rdData = params_ff[paramIndex_ff];
                    end
                end
                OFS_RSV_ZERO, OFS_RSV_ONE: nxt_rdData = UNUSED_WORD;
                default: nxt_rdData = UNUSED_WORD;
            endcase
        end
    end

    // Command state and violation flag
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cmdState_ff <= CMD_IDLE;
            violation_ff <= 1'b0;
        end else begin
            cmdState_ff <= nxt_cmdState;
            violation_ff <= nxt_violation;
        end
    end

    // Before the configuration load everything sits at maximum protection
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pflashProt_ff <= PF_FAULT_VALUE;
            dflashProt_ff <= DF_FAULT_VALUE;
        end else begin
            pflashProt_ff <= nxt_pflashProt;
            dflashProt_ff <= nxt_dflashProt;
        end
    end

    // Array is cleared on reset so parameters of an old command never leak out
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            paramIndex_ff <= '0;
            params_ff <= '{default: UNUSED_WORD};
        end else begin
            paramIndex_ff <= nxt_paramIndex;
            params_ff <= nxt_params;
        end
    end

    // Read data holds between reads, so a late sample still sees the answer
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rdData_ff <= UNUSED_WORD;
        end else begin
            rdData_ff <= nxt_rdData;
        end
    end

    // Outputs
    always_comb begin
        regRdData = rdData_ff;
        commandComplete = (cmdState_ff == CMD_IDLE);
        protectionViolation = violation_ff;
        pflashProtection = pflashProt_ff;
        dflashProtection = dflashProt_ff;
        for (int i = 0; i < PARAM_WORDS; i++) begin
            paramFlat[i*DATA_W +: DATA_W] = params_ff[i];
        end
    end

    pflash_guard_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (wrPflash && !pfAllowed && !cfgValid) |=> $stable(pflashProtection))
        else $error("disallowed scenario write changed program-flash protection");

    pflash_scen_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (!cfgValid && $past(!cfgValid) && $past(nrst))
        |-> SCEN_ALLOWED[scenarioOf($past(pflashProtection))][scenarioOf(pflashProtection)])
        else $error("program-flash protection moved to a forbidden scenario");

    dflash_size_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !cfgValid |=> dflashProtection[DF_SIZE_W-1:0] >= $past(dflashProtection[DF_SIZE_W-1:0]))
        else $error("data-flash protection size shrank");

    dflash_off_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (!cfgValid && !dflashProtection[DF_OFF_BIT]) |=> !dflashProtection[DF_OFF_BIT])
        else $error("data-flash protection off bit went back to 1");

    dflash_fault_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (cfgValid && cfgDoubleFault) |=> (dflashProtection == DF_FAULT_VALUE))
        else $error("double fault did not give maximum data-flash protection");

    erase_refuse_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (chkReq && chkBlockErase && !dflashProtection[DF_OFF_BIT]) |-> chkDenied ##1 protectionViolation)
        else $error("block erase allowed while data flash protected");

    dflash_open_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        dflashProtection[DF_OFF_BIT] |-> !chkDenied)
        else $error("access refused while data-flash protection is off");

    launch_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (wrStatus && regWrData[STAT_COMMAND_COMPLETE_FLAG_BIT] && commandComplete) |-> cmdLaunch ##1 !commandComplete)
        else $error("writing 1 to the complete flag did not launch");

    param_lock_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (wrParam && !commandComplete && !resWrEn) |=> $stable(paramFlat))
        else $error("parameter array changed by software while busy");

    unused_index_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (regRdStrobe && regAddr == OFS_PARAM_DATA && 32'(paramIndex_ff) >= PARAM_WORDS) |=> (regRdData == UNUSED_WORD))
        else $error("unused parameter index read nonzero");

    rsv_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (regRdStrobe && (regAddr == OFS_RSV_ZERO || regAddr == OFS_RSV_ONE)) |=> (regRdData == UNUSED_WORD))
        else $error("factory reserved register read nonzero");

    // Antecedents that look back a cycle also need nrst, so a reset edge is not taken for a move
    launch_busy_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (wrStatus && regWrData[STAT_COMMAND_COMPLETE_FLAG_BIT] && !commandComplete) |-> !cmdLaunch)
        else $error("a launch was accepted while a command was running");

    viol_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        chkDenied |=> protectionViolation)
        else $error("refused access did not set the violation flag");

    dflash_load_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (nrst && cfgValid && !cfgDoubleFault) |=> (dflashProtection == ($past(cfgDflashByte) & DF_USED_MASK)))
        else $error("data-flash protection not loaded from the configuration byte");

    dflash_grow_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (wrDflash && !cfgValid && (dfSizeWr > dfSizeCur)) |=> (dfSizeCur == $past(dfSizeWr)))
        else $error("larger data-flash protection size was not taken");

    pflash_take_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (wrPflash && pfAllowed && !cfgValid) |=> (pflashProtection == $past(pfCandidate)))
        else $error("allowed program-flash protection write was not taken");

    hsize_lock_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (nrst && !cfgValid && !pflashProtection[PF_HDIS_BIT]) |=> $stable(pflashProtection[PF_HS_LSB +: 2]))
        else $error("high range size changed while its range was on");

    lsize_lock_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (nrst && !cfgValid && !pflashProtection[PF_LDIS_BIT]) |=> $stable(pflashProtection[PF_LS_LSB +: 2]))
        else $error("low range size changed while its range was on");

    index_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        wrIndex |=> (paramIndex_ff == $past(regWrData[INDEX_W-1:0])))
        else $error("parameter index write was lost");

    param_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (wrParam && commandComplete && (&regByteEn) && (32'(paramIndex_ff) < PARAM_WORDS))
        |=> (params_ff[$past(paramIndex_ff)] == $past(regWrData)))
        else $error("parameter word write was lost while idle");

    status_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (regRdStrobe && (regAddr == OFS_FLASH_STATUS)) |=> (regRdData[STAT_COMMAND_COMPLETE_FLAG_BIT] == $past(commandComplete)))
        else $error("status read did not show the complete flag");

    result_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (resWrEn && !commandComplete && (32'(resIndex) < PARAM_WORDS))
        |=> (params_ff[$past(resIndex)] == $past(resData)))
        else $error("engine result was not stored");

    done_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (!commandComplete && cmdDone) |=> commandComplete)
        else $error("complete flag did not return after the engine finished");

    first_sector_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (chkReq && !chkBlockErase && !dflashProtection[DF_OFF_BIT]
        && ((chkAddr - DF_BASE_ADDR) < 23'(DF_SECTOR_BYTES))) |-> chkDenied)
        else $error("program or erase allowed in the first protected sector");

    window_cap_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (chkReq && !chkBlockErase && (chkAddr >= DF_BASE_ADDR + 23'(DF_MAX_BYTES)))
        |-> !chkDenied)
        else $error("access refused beyond the largest protected window");
endmodule

// ===== verification/fpc_engine_model.sv
// Behavioural command engine that answers launches after a chosen latency
`timescale 1ns/10ps
module fpc_engine_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Launch and latency
    input wire logic cmdLaunch,
    input wire logic [7:0] lat,
    // Result and completion
    output logic cmdDone,
    output logic resWrEn,
    output logic [2:0] resIndex,
    output logic [15:0] resData
);
    logic busy;
    logic [7:0] cnt;
    // Result lands in word 2 just before completion, while the array is still locked
    assign resIndex = 3'h2;
    assign resData = 16'hA5A5;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            busy <= 1'b0;
            cnt <= 8'h00;
            cmdDone <= 1'b0;
            resWrEn <= 1'b0;
        end else begin
            cmdDone <= 1'b0;
            resWrEn <= 1'b0;
            if (cmdLaunch) begin
                busy <= 1'b1;
                cnt <= lat;
            end else if (busy) begin
                if (cnt == 8'h00) begin
                    busy <= 1'b0;
                    cmdDone <= 1'b1;
                end else begin
                    cnt <= cnt - 8'h01;
                    resWrEn <= (cnt == 8'h01);
                end
            end
        end
    end
endmodule

// ===== verification/test_fpc_protect_cmd.sv
// Self-checking bench for the protection and command parameter block
`timescale 1ns/10ps
module test_fpc_protect_cmd;
    import fpc_pkg::*;
    typedef struct packed {logic [2:0] idx; logic [1:0] en; logic [15:0] data; logic [15:0] exp;} fpc_row_type;
    localparam fpc_row_type ROWS[10] = '{'{3'h0, 2'h3, 16'h1000, 16'h1000}, '{3'h1, 2'h3, 16'h1111, 16'h1111},
        '{3'h2, 2'h3, 16'h2222, 16'h2222}, '{3'h3, 2'h3, 16'h3003, 16'h3003}, '{3'h4, 2'h3, 16'h4444, 16'h4444},
        '{3'h5, 2'h3, 16'h5555, 16'h5555}, '{3'h6, 2'h3, 16'h6666, 16'h0000}, '{3'h7, 2'h3, 16'h7777, 16'h0000},
        '{3'h3, 2'h1, 16'hEE77, 16'h3077}, '{3'h3, 2'h2, 16'h55EE, 16'h5577}};
    // Scenario number to {open,hdis,ldis}, and allowed moves (row = from, bit = to)
    localparam logic [2:0] KEY[8] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b100, 3'b101, 3'b110, 3'b111};
    localparam logic [7:0] OK_MOVE[8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};
    logic sys_clk, nrst, regWrStrobe, regRdStrobe, cfgValid, cfgDoubleFault, cmdLaunch, cmdDone, resWrEn;
    logic commandComplete, chkReq, chkBlockErase, chkDenied, protectionViolation;
    logic [2:0] regAddr, resIndex;
    logic [15:0] regWrData, regRdData, resData;
    logic [1:0] regByteEn;
    logic [7:0] cfgPflashByte, cfgDflashByte, pflashProtection, dflashProtection, engLat;
    logic [95:0] paramFlat;
    logic [22:0] chkAddr;
    int n_errors = 0;
    int n_compared = 0;

    fpc_protect_cmd u_fpc_protect_cmd (.sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
        .regByteEn(regByteEn), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
        .cfgValid(cfgValid), .cfgPflashByte(cfgPflashByte), .cfgDflashByte(cfgDflashByte),
        .cfgDoubleFault(cfgDoubleFault), .cmdLaunch(cmdLaunch), .cmdDone(cmdDone), .resWrEn(resWrEn),
        .resIndex(resIndex), .resData(resData), .paramFlat(paramFlat), .commandComplete(commandComplete),
        .chkReq(chkReq), .chkAddr(chkAddr), .chkBlockErase(chkBlockErase), .chkDenied(chkDenied),
        .protectionViolation(protectionViolation), .pflashProtection(pflashProtection),
        .dflashProtection(dflashProtection));
    fpc_engine_model u_fpc_engine_model (.sys_clk(sys_clk), .nrst(nrst), .cmdLaunch(cmdLaunch), .lat(engLat),
        .cmdDone(cmdDone), .resWrEn(resWrEn), .resIndex(resIndex), .resData(resData));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Each bus task leaves one idle edge so a strobe is never set and cleared in one step
    task automatic wr(input logic [2:0] a, input logic [15:0] d, input logic [1:0] en);
        regAddr <= a;
        regWrData <= d;
        regByteEn <= en;
        regWrStrobe <= 1'b1;
        @(posedge sys_clk);
        regWrStrobe <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        regAddr <= a;
        regRdStrobe <= 1'b1;
        @(posedge sys_clk);
        regRdStrobe <= 1'b0;
        #1 d = regRdData;
        @(posedge sys_clk);
    endtask

    task automatic cfg(input logic [7:0] p, input logic [7:0] df, input logic fault);
        cfgPflashByte <= p;
        cfgDflashByte <= df;
        cfgDoubleFault <= fault;
        cfgValid <= 1'b1;
        @(posedge sys_clk);
        cfgValid <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic chk(input logic [22:0] a, input logic be, input logic exp);
        chkAddr <= a;
        chkBlockErase <= be;
        chkReq <= 1'b1;
        #1 check(16'(chkDenied), 16'(exp));
        @(posedge sys_clk);
        chkReq <= 1'b0;
        #1 check(16'(protectionViolation), 16'(exp));
        @(posedge sys_clk);
    endtask

    task automatic launch(input logic [7:0] l);
        engLat <= l;
        regAddr <= OFS_FLASH_STATUS;
        regWrData <= 16'h0080;
        regByteEn <= 2'h1;
        regWrStrobe <= 1'b1;
        #1 check(16'(cmdLaunch), 16'h0001);
        @(posedge sys_clk);
        regWrStrobe <= 1'b0;
        #1 check(16'(commandComplete), 16'h0000);
        @(posedge sys_clk);
    endtask

    function automatic logic [7:0] sb(input int s);
        return {KEY[s][2], 1'b0, KEY[s][1], 2'b00, KEY[s][0], 2'b00};
    endfunction

    initial begin
        #(25ns * 20000);
        n_errors++;
        wrap_up();
    end

    initial begin
        logic [15:0] v;
        {regWrStrobe, regRdStrobe, cfgValid, cfgDoubleFault, chkReq, chkBlockErase} = '0;
        {regAddr, regWrData, regByteEn, cfgPflashByte, cfgDflashByte, chkAddr} = '0;
        engLat = 8'h03;
        nrst = 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        #1 check(16'(dflashProtection), 16'h001F);
        check(16'(commandComplete), 16'h0001);
        @(posedge sys_clk);
        foreach (ROWS[i]) begin
            wr(OFS_PARAM_INDEX, 16'(ROWS[i].idx), 2'h1);
            wr(OFS_PARAM_DATA, ROWS[i].data, ROWS[i].en);
            rd(OFS_PARAM_DATA, v);
            check(v, ROWS[i].exp);
        end
        check(paramFlat[63:48], 16'h5577);
        cfg(8'hFF, 8'h55, 1'b1);
        check(16'(dflashProtection), 16'h001F);
        cfg(8'hA4, 8'h83, 1'b0);
        check(16'(dflashProtection), 16'h0083);
        chk(23'h10_0010, 1'b0, 1'b0);
        chk(23'h10_0010, 1'b1, 1'b0);
        wr(OFS_PFLASH_PROT, 16'h00BF, 2'h1);
        rd(OFS_PFLASH_PROT, v);
        check(v, 16'h00BF);
        wr(OFS_DFLASH_PROT, 16'h0005, 2'h1);
        wr(OFS_DFLASH_PROT, 16'h0085, 2'h1);
        check(16'(dflashProtection), 16'h0005);
        wr(OFS_DFLASH_PROT, 16'h0004, 2'h1);
        check(16'(dflashProtection), 16'h0005);
        wr(OFS_DFLASH_PROT, 16'h0006, 2'h1);
        rd(OFS_DFLASH_PROT, v);
        check(v, 16'h0006);
        chk(23'h10_06FF, 1'b0, 1'b1);
        wr(OFS_FLASH_STATUS, 16'h0020, 2'h1);
        chk(23'h10_0700, 1'b0, 1'b0);
        chk(23'h10_0F00, 1'b1, 1'b1);
        wr(OFS_FLASH_STATUS, 16'h0020, 2'h1);
        for (int f = 0; f < 8; f++) begin
            for (int t = 0; t < 8; t++) begin
                cfg(sb(f), 8'h80, 1'b0);
                wr(OFS_PFLASH_PROT, 16'(sb(t)), 2'h1);
                check(16'(pflashProtection), 16'(OK_MOVE[f][t] ? sb(t) : sb(f)));
            end
        end
        wr(OFS_PFLASH_PROT, 16'h001B, 2'h1);
        check(16'(pflashProtection), 16'h001B);
        cfg(8'h00, 8'h80, 1'b0);
        wr(OFS_PFLASH_PROT, 16'h001B, 2'h1);
        check(16'(pflashProtection), 16'h0000);
        wr(OFS_PARAM_INDEX, 16'h0000, 2'h1);
        wr(OFS_PARAM_DATA, 16'h1234, 2'h3);
        for (int k = 0; k < 2; k++) begin
            launch(k == 0 ? 8'h03 : 8'h14);
            wr(OFS_PARAM_DATA, 16'hFFFF, 2'h3);
            for (int w = 0; w < 100 && commandComplete !== 1'b1; w++)
                @(posedge sys_clk);
            check(16'(commandComplete), 16'h0001);
            rd(OFS_PARAM_DATA, v);
            check(v, 16'h1234);
        end
        check(paramFlat[47:32], 16'hA5A5);
        wr(OFS_RSV_ZERO, 16'hFFFF, 2'h3);
        wr(OFS_RSV_ONE, 16'hFFFF, 2'h3);
        for (int a = 5; a < 8; a++) begin
            rd(3'(a), v);
            check(v, 16'h0000);
        end
        nrst <= 1'b0;
        @(posedge sys_clk);
        nrst <= 1'b1;
        #1 check(paramFlat[15:0], 16'h0000);
        wrap_up();
    end
endmodule
